//--- inc/sfc_pkg.sv
// Shared constants, types and the opcode decoder of the serial flash command front end.
// Assumes it is compiled before every module that imports it.
package sfc_pkg;

    // Lane codes: a phase moves 1 << code bits per serial clock.
    localparam logic [1:0] SFC_LN1 = 2'h0;
    localparam logic [1:0] SFC_LN2 = 2'h1;
    localparam logic [1:0] SFC_LN4 = 2'h2;

    // Output enables of the data lanes, pin order {hold, wp, so, si}.
    localparam logic [3:0] SFC_OE_X1 = 4'h2;
    localparam logic [3:0] SFC_OE_X2 = 4'h3;
    localparam logic [3:0] SFC_OE_X4 = 4'hF;

    // Supported opcodes.
    localparam logic [7:0] SFC_OP_READ  = 8'h03;
    localparam logic [7:0] SFC_OP_FAST  = 8'h0B;
    localparam logic [7:0] SFC_OP_DOUT  = 8'h3B;
    localparam logic [7:0] SFC_OP_DIO   = 8'hBB;
    localparam logic [7:0] SFC_OP_QOUT  = 8'h6B;
    localparam logic [7:0] SFC_OP_QIO   = 8'hEB;
    localparam logic [7:0] SFC_OP_WQIO  = 8'hE7;
    localparam logic [7:0] SFC_OP_WRAP  = 8'h77;
    localparam logic [7:0] SFC_OP_WREN  = 8'h06;
    localparam logic [7:0] SFC_OP_VWREN = 8'h50;
    localparam logic [7:0] SFC_OP_WRDI  = 8'h04;
    localparam logic [7:0] SFC_OP_PP    = 8'h02;
    localparam logic [7:0] SFC_OP_QPP   = 8'h32;
    localparam logic [7:0] SFC_OP_RSTEN = 8'h66;
    localparam logic [7:0] SFC_OP_RST   = 8'h99;
    localparam logic [7:0] SFC_OP_DPD   = 8'hB9;
    localparam logic [7:0] SFC_OP_RDPD  = 8'hAB;

    // Dummy clock counts.
    localparam logic [4:0] SFC_DUM_FAST = 5'h08;
    localparam logic [4:0] SFC_DUM_QIO  = 5'h04;
    localparam logic [4:0] SFC_DUM_WQIO = 5'h02;
    localparam logic [4:0] SFC_DUM_WRAP = 5'h06;

    // Bit counts of the address and of one byte.
    localparam logic [4:0] SFC_ADDR_BITS = 5'h18;
    localparam logic [4:0] SFC_BYTE_BITS = 5'h08;
    localparam int         SFC_ADDR_W    = 19;

    // Mode byte pattern that keeps continuous read armed.
    localparam logic [7:0] SFC_CONT_MASK  = 8'h30;
    localparam logic [7:0] SFC_CONT_MATCH = 8'h20;

    // Meaningful bits of the wrap setup byte, and the byte sent when no read data waits.
    localparam logic [7:0] SFC_WRAP_MASK = 8'h70;
    localparam logic [7:0] SFC_IDLE_BYTE = 8'hFF;

    // Reset value of the synchronised pins {cs_n, sck, io[3:0]}.
    localparam logic [5:0] SFC_PIN_RST = 6'h20;

    // Frame phases.
    typedef enum logic [2:0] {
        SFC_IDLE,
        SFC_OPC,
        SFC_ADDR,
        SFC_MODE,
        SFC_DUMMY,
        SFC_RDATA,
        SFC_WDATA,
        SFC_SKIP
    } sfc_phase_e;

    // Decoded shape of one command.
    typedef struct packed {
        logic       ok;
        logic       addr;
        logic [1:0] alane;
        logic       mode;
        logic [4:0] dummy;
        logic       rd;
        logic       wr;
        logic [1:0] dlane;
    } sfc_cmd_s;

    // Maps an opcode to its phases; unknown opcodes come back with ok low.
    function automatic sfc_cmd_s sfc_decode(input logic [7:0] op);
        sfc_cmd_s c;
        c    = '0;
        c.ok = 1'b1;
        case (op)
            SFC_OP_READ: begin
                c.addr = 1'b1;
                c.rd   = 1'b1;
            end
            SFC_OP_FAST, SFC_OP_DOUT, SFC_OP_QOUT: begin
                c.addr  = 1'b1;
                c.rd    = 1'b1;
                c.dummy = SFC_DUM_FAST;
                c.dlane = (op == SFC_OP_DOUT) ? SFC_LN2 : (op == SFC_OP_QOUT) ? SFC_LN4 : SFC_LN1;
            end
            SFC_OP_DIO: begin
                c.addr  = 1'b1;
                c.alane = SFC_LN2;
                c.mode  = 1'b1;
                c.rd    = 1'b1;
                c.dlane = SFC_LN2;
            end
            SFC_OP_QIO, SFC_OP_WQIO: begin
                c.addr  = 1'b1;
                c.alane = SFC_LN4;
                c.mode  = 1'b1;
                c.dummy = (op == SFC_OP_QIO) ? SFC_DUM_QIO : SFC_DUM_WQIO;
                c.rd    = 1'b1;
                c.dlane = SFC_LN4;
            end
            SFC_OP_WRAP: begin
                c.dummy = SFC_DUM_WRAP;
                c.wr    = 1'b1;
                c.dlane = SFC_LN4;
            end
            SFC_OP_PP, SFC_OP_QPP: begin
                c.addr  = 1'b1;
                c.wr    = 1'b1;
                c.dlane = (op == SFC_OP_QPP) ? SFC_LN4 : SFC_LN1;
            end
            SFC_OP_WREN, SFC_OP_VWREN, SFC_OP_WRDI, SFC_OP_RSTEN, SFC_OP_RST, SFC_OP_DPD,
            SFC_OP_RDPD: begin
                c.ok = 1'b1;
            end
            default: begin
                c.ok = 1'b0;
            end
        endcase
        return c;
    endfunction : sfc_decode

endpackage : sfc_pkg

//--- verilog/sfc_sync.sv
// Two flip-flop synchroniser for a bundle of pin levels.
// Assumes the inputs are asynchronous to clk_in and change slowly against it.
`timescale 1ns/100ps
module sfc_sync
    import sfc_pkg::*;
#(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk_in,
    input  wire logic         rstn_in,
    input  wire logic         ce_in,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } sfc_sync_s;

    sfc_sync_s st_reg;
    sfc_sync_s st_next;

    // The first stage is read only by the second stage.
    always_comb begin
        st_next = st_reg;
        if (ce_in) begin
            st_next.meta   = d_in;
            st_next.stable = st_reg.meta;
        end
    end

    // State register with asynchronous reset to the idle pin levels.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_reg <= {RST_VAL, RST_VAL};
        end else begin
            st_reg <= st_next;
        end
    end

    assign q_out = st_reg.stable;

endmodule : sfc_sync

//--- verilog/sfc_buf.sv
// Small first-in first-out buffer with valid and ready on both sides.
// Assumes both sides run on clk_in; ce_in low freezes it.
`timescale 1ns/100ps
module sfc_buf
    import sfc_pkg::*;
#(
    parameter int W     = 8,
    parameter int DEPTH = 2
) (
    input  wire logic         clk_in,
    input  wire logic         rstn_in,
    input  wire logic         ce_in,
    input  wire logic [W-1:0] in_data_in,
    input  wire logic         in_valid_in,
    output logic              in_ready_out,
    output logic      [W-1:0] out_data_out,
    output logic              out_valid_out,
    input  wire logic         out_ready_in
);

    localparam int AW    = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = AW + 1;

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wp;
        logic [AW-1:0]           rp;
        logic [CNT_W-1:0]        cnt;
    } sfc_buf_s;

    sfc_buf_s st_reg;
    sfc_buf_s st_next;
    logic     push;
    logic     pop;

    // Full and empty come straight from the fill count.
    assign in_ready_out  = (st_reg.cnt != CNT_W'(DEPTH));
    assign out_valid_out = (st_reg.cnt != '0);
    assign out_data_out  = st_reg.mem[st_reg.rp];
    assign push          = ce_in & in_valid_in & in_ready_out;
    assign pop           = ce_in & out_ready_in & out_valid_out;

    // Pointers wrap at the depth; the count tracks pushes against pops.
    always_comb begin
        st_next = st_reg;
        if (push) begin
            st_next.mem[st_reg.wp] = in_data_in;
            st_next.wp = (st_reg.wp == AW'(DEPTH - 1)) ? '0 : st_reg.wp + 1'b1;
        end
        if (pop) begin
            st_next.rp = (st_reg.rp == AW'(DEPTH - 1)) ? '0 : st_reg.rp + 1'b1;
        end
        if (push && !pop) begin
            st_next.cnt = st_reg.cnt + 1'b1;
        end else if (pop && !push) begin
            st_next.cnt = st_reg.cnt - 1'b1;
        end
    end

    // State register.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

endmodule : sfc_buf

//--- verilog/sfc_frontend.sv
// Serial command front end of a serial NOR flash: frames, decodes and moves data lanes.
// Assumes the pins are asynchronous to clk_in, the serial clock is far slower than
// clk_in, and the array side answers read requests on clk_in.
//
// Functional notes
// - Modes 0 and 3 only; sample on rising clock, change output on falling.
// - Dual-output read drives two bits per clock; input pin becomes output.
// - Dual I/O: opcode on one line, address and data on two.
// - Quad-output read drives four bits per clock on all four pins.
// - Quad I/O: address in on four pins, data out on four pins.
// - Opcode, address and data move most significant bit first.
// - Chip select deassertion ends the current command.
// - Unknown opcode starts nothing; input ignored until chip select cycles.
// - Chip select lost before opcode and address: abandon, return idle.
// - Three address bytes; upper five address bits are ignored.
// - 03h reads without dummy clocks; 0Bh inserts 8 dummy clocks.
// - 3Bh: single-line opcode and address, 8 dummy clocks, dual data.
// - BBh: dual address, 4 mode clocks, no dummy; continuous skips opcode.
// - 6Bh: single-line opcode and address, 8 dummy clocks, quad data.
// - EBh: quad address, 2 mode clocks, 4 dummy; continuous skips opcode.
// - E7h: quad address, 2 mode clocks, 2 dummy; continuous variant too.
// - 77h: no address, 6 dummy, one quad byte with D[6:4] meaningful.
// - 06h, 50h, 04h are opcode-only commands.
// - 02h single-line program; 32h single-line address, quad data.
// - 66h, 99h, B9h, ABh are opcode-only commands.
// - A byte takes 8, 4 or 2 clocks by lane count.
// - Address with mode: 12 plus 4 clocks dual, 6 plus 2 quad.
`timescale 1ns/100ps
module sfc_frontend
    import sfc_pkg::*;
#(
    parameter int ADDR_W    = SFC_ADDR_W,
    parameter int BUF_DEPTH = 2
) (
    input  wire logic              clk_in,
    input  wire logic              rstn_in,
    input  wire logic              ce_in,
    input  wire logic              cs_n_in,
    input  wire logic              sck_in,
    input  wire logic [3:0]        io_in,
    output logic      [3:0]        io_out,
    output logic      [3:0]        io_oe_out,
    output logic                   cmd_valid_out,
    output logic      [7:0]        cmd_op_out,
    output logic      [ADDR_W-1:0] cmd_addr_out,
    output logic                   cont_mode_out,
    output logic                   frame_end_out,
    input  wire logic [7:0]        rd_data_in,
    input  wire logic              rd_valid_in,
    output logic                   rd_ready_out,
    output logic      [7:0]        wr_data_out,
    output logic                   wr_valid_out,
    input  wire logic              wr_ready_in,
    output logic                   wr_overrun_out
);

    typedef struct packed {
        sfc_phase_e        phase;
        sfc_cmd_s          info;
        logic [7:0]        op;
        logic [4:0]        cnt;
        logic [23:0]       sh_in;
        logic [7:0]        sh_out;
        logic [ADDR_W-1:0] addr;
        logic [3:0]        dout;
        logic [3:0]        oe;
        logic              sck_d;
        logic              cont;
        logic              cmd_v;
        logic              end_p;
        logic              overrun;
        logic [7:0]        wbyte;
        logic              wv;
    } sfc_state_s;

    sfc_state_s st_reg;
    sfc_state_s st_next;
    logic [5:0] pins_s;
    logic       cs_n_s;
    logic       sck_s;
    logic [3:0] io_s;
    logic       wr_in_ready;
    logic       rd_take;

    // Clocks needed to move a number of bits over the lanes of a code.
    function automatic logic [4:0] lane_clks(input logic [4:0] bits, input logic [1:0] code);
        return bits >> code;
    endfunction : lane_clks

    // Number of bits that move per clock for a lane code.
    function automatic logic [2:0] lane_width(input logic [1:0] code);
        return 3'h1 << code;
    endfunction : lane_width

    // Shifts the sampled lanes in at the bottom, most significant bit first.
    function automatic logic [23:0] lane_shift(input logic [23:0] v, input logic [3:0] io,
                                               input logic [1:0] code);
        case (code)
            SFC_LN2: return {v[21:0], io[1:0]};
            SFC_LN4: return {v[19:0], io[3:0]};
            default: return {v[22:0], io[0]};
        endcase
    endfunction : lane_shift

    // Places the top bits of a byte on the data lanes.
    function automatic logic [3:0] lane_out(input logic [7:0] b, input logic [1:0] code);
        case (code)
            SFC_LN2: return {2'h0, b[7:6]};
            SFC_LN4: return b[7:4];
            default: return {2'h0, b[7], 1'h0};
        endcase
    endfunction : lane_out

    // Output enables of the data lanes for a lane code.
    function automatic logic [3:0] lane_oe(input logic [1:0] code);
        case (code)
            SFC_LN2: return SFC_OE_X2;
            SFC_LN4: return SFC_OE_X4;
            default: return SFC_OE_X1;
        endcase
    endfunction : lane_oe

    // Phase that follows dummy clocks, or that follows address and mode without them.
    function automatic sfc_phase_e data_phase(input sfc_cmd_s c);
        if (c.rd) begin
            return SFC_RDATA;
        end else if (c.wr) begin
            return SFC_WDATA;
        end
        return SFC_SKIP;
    endfunction : data_phase

    function automatic sfc_phase_e after_addr(input sfc_cmd_s c);
        return (c.dummy != '0) ? SFC_DUMMY : data_phase(c);
    endfunction : after_addr

    // Chip select, serial clock and data pins pass two flip-flops first.
    sfc_sync #(
        .W       (6),
        .RST_VAL (SFC_PIN_RST)
    ) u_sync (
        .clk_in  (clk_in),
        .rstn_in (rstn_in),
        .ce_in   (ce_in),
        .d_in    ({cs_n_in, sck_in, io_in}),
        .q_out   (pins_s)
    );

    assign cs_n_s = pins_s[5];
    assign sck_s  = pins_s[4];
    assign io_s   = pins_s[3:0];

    // Received program bytes wait here so a short array stall loses nothing.
    sfc_buf #(
        .W     (8),
        .DEPTH (BUF_DEPTH)
    ) u_wbuf (
        .clk_in        (clk_in),
        .rstn_in       (rstn_in),
        .ce_in         (ce_in),
        .in_data_in    (st_reg.wbyte),
        .in_valid_in   (st_reg.wv),
        .in_ready_out  (wr_in_ready),
        .out_data_out  (wr_data_out),
        .out_valid_out (wr_valid_out),
        .out_ready_in  (wr_ready_in)
    );

    // A read byte is taken on the falling edge that starts a new output byte.
    assign rd_take = ce_in & ~cs_n_s & ~sck_s & st_reg.sck_d &
                     (st_reg.phase == SFC_RDATA) & (st_reg.cnt == '0);
    assign rd_ready_out = rd_take;

    // Frame sequencer: phases advance on rising serial clock edges.
    always_comb begin
        logic       rise;
        logic       fall;
        logic [7:0] b;
        rise = sck_s & ~st_reg.sck_d;
        fall = ~sck_s & st_reg.sck_d;
        b    = '0;
        st_next       = st_reg;
        st_next.sck_d = sck_s;
        st_next.cmd_v = 1'b0;
        st_next.end_p = 1'b0;
        st_next.wv    = 1'b0;
        if (cs_n_s) begin
            // Chip select high closes the frame and releases the pins.
            if (st_reg.phase != SFC_IDLE) begin
                st_next.end_p = 1'b1;
            end
            st_next.phase = SFC_IDLE;
            st_next.oe    = '0;
            st_next.dout  = '0;
        end else if (st_reg.phase == SFC_IDLE) begin
            // A new frame; continuous read skips the opcode phase.
            st_next.cnt     = '0;
            st_next.overrun = 1'b0;
            st_next.phase   = st_reg.cont ? SFC_ADDR : SFC_OPC;
        end else if (rise) begin
            st_next.cnt = st_reg.cnt + 5'h01;
            case (st_reg.phase)
                SFC_OPC: begin
                    st_next.sh_in = lane_shift(st_reg.sh_in, io_s, SFC_LN1);
                    if (st_reg.cnt == SFC_BYTE_BITS - 5'h01) begin
                        st_next.cnt  = '0;
                        st_next.op   = st_next.sh_in[7:0];
                        st_next.info = sfc_decode(st_next.sh_in[7:0]);
                        if (!st_next.info.ok) begin
                            st_next.phase = SFC_SKIP;
                        end else if (st_next.info.addr) begin
                            st_next.phase = SFC_ADDR;
                        end else begin
                            st_next.cmd_v = 1'b1;
                            st_next.phase = after_addr(st_next.info);
                        end
                    end
                end
                SFC_ADDR: begin
                    st_next.sh_in = lane_shift(st_reg.sh_in, io_s, st_reg.info.alane);
                    if (st_reg.cnt == lane_clks(SFC_ADDR_BITS, st_reg.info.alane) - 5'h01) begin
                        st_next.cnt   = '0;
                        st_next.addr  = st_next.sh_in[ADDR_W-1:0];
                        st_next.cmd_v = 1'b1;
                        st_next.phase = st_reg.info.mode ? SFC_MODE : after_addr(st_reg.info);
                    end
                end
                SFC_MODE: begin
                    st_next.sh_in = lane_shift(st_reg.sh_in, io_s, st_reg.info.alane);
                    if (st_reg.cnt == lane_clks(SFC_BYTE_BITS, st_reg.info.alane) - 5'h01) begin
                        // Mode bits decide whether the next frame skips its opcode.
                        st_next.cnt   = '0;
                        st_next.cont  = ((st_next.sh_in[7:0] & SFC_CONT_MASK) == SFC_CONT_MATCH);
                        st_next.phase = after_addr(st_reg.info);
                    end
                end
                SFC_DUMMY: begin
                    if (st_reg.cnt == st_reg.info.dummy - 5'h01) begin
                        st_next.cnt   = '0;
                        st_next.phase = data_phase(st_reg.info);
                    end
                end
                SFC_WDATA: begin
                    st_next.sh_in = lane_shift(st_reg.sh_in, io_s, st_reg.info.dlane);
                    if (st_reg.cnt == lane_clks(SFC_BYTE_BITS, st_reg.info.dlane) - 5'h01) begin
                        st_next.cnt   = '0;
                        st_next.wv    = 1'b1;
                        st_next.wbyte = (st_reg.op == SFC_OP_WRAP) ?
                                        (st_next.sh_in[7:0] & SFC_WRAP_MASK) :
                                        st_next.sh_in[7:0];
                    end
                end
                default: begin
                    st_next.cnt = st_reg.cnt;
                end
            endcase
        end else if (fall && st_reg.phase == SFC_RDATA) begin
            // Data lanes turn to outputs and change on the falling edge.
            b = (st_reg.cnt != '0) ? st_reg.sh_out : rd_valid_in ? rd_data_in : SFC_IDLE_BYTE;
            st_next.oe     = lane_oe(st_reg.info.dlane);
            st_next.dout   = lane_out(b, st_reg.info.dlane);
            st_next.sh_out = b << lane_width(st_reg.info.dlane);
            st_next.cnt    = (st_reg.cnt == lane_clks(SFC_BYTE_BITS, st_reg.info.dlane) - 5'h01) ?
                             5'h00 : st_reg.cnt + 5'h01;
        end
        // A byte refused by a full buffer is flagged; the set wins over the frame clear.
        if (st_reg.wv && !wr_in_ready) begin
            st_next.overrun = 1'b1;
        end
    end

    // State register; clock enable low freezes everything.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_reg <= '0;
        end else if (ce_in) begin
            st_reg <= st_next;
        end
    end

    // Outputs come from the state register.
    assign io_out         = st_reg.dout;
    assign io_oe_out      = st_reg.oe;
    assign cmd_valid_out  = st_reg.cmd_v;
    assign cmd_op_out     = st_reg.op;
    assign cmd_addr_out   = st_reg.addr;
    assign cont_mode_out  = st_reg.cont;
    assign frame_end_out  = st_reg.end_p;
    assign wr_overrun_out = st_reg.overrun;

endmodule : sfc_frontend

//--- bench/sfc_host.sv
// Host master model: chip select, serial clock and data lanes in mode 0.
// Assumes the bench resolves the shared lanes from the front end's output enables.
`timescale 1ns/100ps
module sfc_host (
    output logic            cs_n_out,
    output logic            sck_out,
    output logic      [3:0] io_out,
    input  wire logic [3:0] io_in
);
    // Idle: deselected, clock low.
    initial begin
        cs_n_out = 1'b1;
        sck_out = 1'b0;
        io_out = 4'hF;
    end
    // Opens a frame before any clock.
    task automatic go();
        #100 cs_n_out = 1'b0;
        #100;
    endtask : go
    // Closes the frame after the last fall.
    task automatic stop();
        #100 cs_n_out = 1'b1;
        #100;
    endtask : stop
    // Shifts n bits, ln a clock; released lanes show the inverse level.
    task automatic tx(input logic [31:0] v, input int n, input int ln);
        for (int i = n; i > 0; i -= ln) begin
            io_out = 4'((v >> (i - ln)) & ((32'h1 << ln) - 32'h1));
            #62.5 sck_out = 1'b1;
            #62.5 sck_out = 1'b0;
        end
        io_out = ~io_out;
    endtask : tx
    // Samples ln read lanes at each rising edge.
    task automatic rx(input int n, input int ln, output logic [31:0] v);
        v = '0;
        repeat (n) begin
            #62.5 sck_out = 1'b1;
            v = (v << ln) | ((ln == 1) ? 32'(io_in[1]) : 32'(io_in & 4'((1 << ln) - 1)));
            #62.5 sck_out = 1'b0;
        end
    endtask : rx
endmodule : sfc_host

//--- bench/sfc_frontend_chk.sv
// Port checks of the command front end.
// Assumes slow host clock edges against clk_in.
`timescale 1ns/100ps
module sfc_frontend_chk (
    input wire logic       clk_in,
    input wire logic       rstn_in,
    input wire logic       cs_n_in,
    input wire logic       sck_in,
    input wire logic [3:0] io_out,
    input wire logic [3:0] io_oe_out,
    input wire logic       cmd_valid_out,
    input wire logic [7:0] cmd_op_out,
    input wire logic       cont_mode_out,
    input wire logic       frame_end_out,
    input wire logic       rd_ready_out,
    input wire logic [7:0] wr_data_out,
    input wire logic       wr_valid_out,
    input wire logic       wr_ready_in
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    // A rise of chip select closes the frame.
    sequence s_cs_up;
        $rose(cs_n_in);
    endsequence
    AST_FRAME_END: assert property (s_cs_up |-> ##[1:6] frame_end_out)
        else $error("frame end missing");
    AST_OE_DROP: assert property (s_cs_up |-> ##[1:6] io_oe_out == 4'h0)
        else $error("lanes not released");
    AST_OE_SET: assert property (io_oe_out inside {4'h0, 4'h2, 4'h3, 4'hF})
        else $error("bad lane enables");
    AST_OUT_ON_FALL: assert property (io_oe_out != 4'h0 && $changed(io_out) |-> !sck_in)
        else $error("output moved with clock high");
    AST_CV_OP: assert property (cmd_valid_out |-> cmd_op_out inside {8'h03, 8'h0B, 8'h3B,
        8'hBB, 8'h6B, 8'hEB, 8'hE7, 8'h77, 8'h06, 8'h50, 8'h04, 8'h02, 8'h32, 8'h66, 8'h99,
        8'hB9, 8'hAB})
        else $error("command on unknown opcode");
    AST_RD_PHASE: assert property (rd_ready_out |=> io_oe_out != 4'h0)
        else $error("read take outside data phase");
    AST_WR_HOLD: assert property (wr_valid_out && !wr_ready_in |=> wr_valid_out
        && $stable(wr_data_out))
        else $error("write head lost");
    AST_CONT_OP: assert property ($rose(cont_mode_out) |-> cmd_op_out inside {8'hBB, 8'hEB,
        8'hE7})
        else $error("continuous mode on wrong opcode");
endmodule : sfc_frontend_chk
bind sfc_frontend sfc_frontend_chk u_sfc_frontend_chk (.*);

//--- bench/tb_top.sv
// Bench of the command front end with a host model on the link.
// Assumes 125 MHz clk_in and a 125 ns host serial clock.
`timescale 1ns/100ps
module tb_top;
    logic clk_in = 1'b0, rstn_in = 1'b0, wr_ready = 1'b0;
    logic cs_n, sck, cmd_valid, cont, fend, rd_ready, wr_valid, ovr;
    logic [3:0] h_io, io_o, io_oe, io_w;
    logic [7:0] op, cv_op, wr_data, rd_byte = 8'h5A;
    logic [18:0] addr, cv_addr;
    logic [7:0] oo [7] = '{8'h06, 8'h50, 8'h04, 8'h66, 8'h99, 8'hB9, 8'hAB};
    int error_cnt = 0, checks = 0, ncv = 0, cyc = 0;
    // Each lane follows whichever party drives it.
    assign io_w = (io_oe & io_o) | (~io_oe & h_io);
    sfc_host u_sfc_host (.cs_n_out(cs_n), .sck_out(sck), .io_out(h_io), .io_in(io_w));
    sfc_frontend u_sfc_frontend (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(1'b1),
        .cs_n_in(cs_n), .sck_in(sck), .io_in(io_w), .io_out(io_o), .io_oe_out(io_oe),
        .cmd_valid_out(cmd_valid), .cmd_op_out(op), .cmd_addr_out(addr),
        .cont_mode_out(cont), .frame_end_out(fend), .rd_data_in(rd_byte),
        .rd_valid_in(rstn_in), .rd_ready_out(rd_ready), .wr_data_out(wr_data),
        .wr_valid_out(wr_valid), .wr_ready_in(wr_ready), .wr_overrun_out(ovr));
    always #4 clk_in = ~clk_in;
    // Array side, command capture and hang guard.
    always @(posedge clk_in) begin
        if (rd_ready) rd_byte <= rd_byte + 8'h11;
        if (cmd_valid) begin
            ncv <= ncv + 1;
            cv_op <= op;
            cv_addr <= addr;
        end
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            error_cnt = error_cnt + 1;
            final_report();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic final_report();
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : final_report
    // Read frame: opcode unless skipped, address, mode, dummy, one byte.
    task automatic s_rd(input logic [7:0] o, input int skip, al, mb, dum, dl,
                        input logic [3:0] oe, input logic [7:0] md);
        logic [31:0] v;
        logic [7:0] e;
        int n0;
        n0 = ncv;
        e = rd_byte;
        u_sfc_host.go();
        if (skip == 0) u_sfc_host.tx(o, 8, 1);
        u_sfc_host.tx(32'hFAB5C3, 24, al);
        u_sfc_host.tx(md, mb, al);
        u_sfc_host.tx(0, dum, 1);
        u_sfc_host.rx(8 / dl, dl, v);
        chk("oe", oe, io_oe);
        u_sfc_host.stop();
        chk("data", e, v);
        chk("ncv", n0 + 1, ncv);
        chk("op", o, cv_op);
        chk("addr", 32'h2B5C3, cv_addr);
        chk("cont", mb > 0 && md[5:4] == 2'h2, cont);
    endtask : s_rd
    // Opcode frame with stray bits; hit tells if a command fires.
    task automatic s_op(input logic [7:0] o, input int hit);
        int n0;
        n0 = ncv;
        u_sfc_host.go();
        u_sfc_host.tx(o, 8, 1);
        u_sfc_host.tx(32'h06, 8, 1);
        u_sfc_host.stop();
        chk("ncv", n0 + hit, ncv);
    endtask : s_op
    // Write frame with the array stalled, then a drain of the buffer.
    task automatic s_wr(input logic [7:0] o, input int na, dum, dl, nb,
                        input logic [31:0] d, input logic [7:0] e);
        int n;
        n = 0;
        u_sfc_host.go();
        u_sfc_host.tx(o, 8, 1);
        u_sfc_host.tx(32'h012345, na, 1);
        u_sfc_host.tx(0, dum, 1);
        u_sfc_host.tx(d, nb * 8, dl);
        u_sfc_host.stop();
        chk("head", e, wr_data);
        chk("ovr", nb > 2, ovr);
        @(posedge clk_in) #1 wr_ready = 1'b1;
        repeat (4) begin
            @(negedge clk_in);
            n += wr_valid;
        end
        #1 wr_ready = 1'b0;
        chk("pops", (nb > 2) ? 2 : nb, n);
    endtask : s_wr
    // Main sequence after a three-cycle reset.
    initial begin
        repeat (3) @(posedge clk_in);
        #1 rstn_in = 1'b1;
        s_rd(8'h03, 0, 1, 0, 0, 1, 4'h2, 8'h00);
        s_rd(8'h0B, 0, 1, 0, 8, 1, 4'h2, 8'h00);
        s_rd(8'h3B, 0, 1, 0, 8, 2, 4'h3, 8'h00);
        s_rd(8'h6B, 0, 1, 0, 8, 4, 4'hF, 8'h00);
        s_rd(8'hBB, 0, 2, 8, 0, 2, 4'h3, 8'h20);
        s_rd(8'hBB, 1, 2, 8, 0, 2, 4'h3, 8'h00);
        s_rd(8'hEB, 0, 4, 8, 4, 4, 4'hF, 8'h20);
        s_rd(8'hEB, 1, 4, 8, 4, 4, 4'hF, 8'h00);
        s_rd(8'hE7, 0, 4, 8, 2, 4, 4'hF, 8'h20);
        s_rd(8'hE7, 1, 4, 8, 2, 4, 4'hF, 8'h00);
        s_op(8'h9F, 0);
        s_op(8'h03, 0);
        foreach (oo[i]) s_op(oo[i], 1);
        s_wr(8'h02, 24, 0, 1, 3, 32'hA1B2C3, 8'hA1);
        s_wr(8'h32, 24, 0, 4, 2, 32'h5AA5, 8'h5A);
        s_wr(8'h77, 0, 6, 4, 1, 32'hFF, 8'h70);
        final_report();
    end
endmodule : tb_top
